// File: rtl/srpd_top.sv
`timescale 1ns/1ps
`default_nettype none
module srpd_top
  import srpd_pkg::*;
(
  input  wire logic        sys_clk,       // 100 MHz clock
  input  wire logic        resetn,        // Sync reset, active low
  input  wire logic [5:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [5:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire logic        cmd_complete,  // Command finished pulse
  input  wire logic        media_error,   // Sector error pulse
  input  wire logic [47:0] error_lba,     // LBA of failing sector
  input  wire logic [15:0] error_count,   // Possibly bad sectors
  output logic [16:0]      xfer_sectors,  // Sectors to transfer
  output logic [47:0]      start_lba,     // First LBA
  output logic             cmd_active,    // Command under way
  output logic             cmd_abort,     // Stop pulse on expiry
  output logic             irq            // Interrupt level
);
  // --------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------
  logic [31:0] task_reg;
  logic [23:0] lba_cur;
  logic [23:0] lba_prv;
  logic [31:0] unit_reg;
  logic [31:0] min_reg;
  logic [2:0]  irq_st;
  logic [2:0]  irq_msk;

  logic        aw_got;
  logic        w_got;
  logic [5:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        wr_hit;
  logic        rd_hit;

  srpd_state_t state;
  logic        read_continuous;
  logic [47:0] limit_us;
  logic        limit_on;
  logic [6:0]  tick_cnt;
  logic [47:0] us_cnt;
  logic        expired;
  logic        stream_error_flag;
  logic        time_limit_expired_flag;
  logic        err_flag;
  logic [47:0] err_lba;
  logic [15:0] err_cnt;
  logic        cmd_go;
  logic [2:0]  irq_set;
  logic [47:0] req_us;
  logic        req_on;

  srpd_mem_if mif ();

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  function automatic logic mapped(input logic [5:0] a);
    mapped = (a[5:2] <= REG_IRQ_MSK[5:2]);
  endfunction : mapped

  // --------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign wr_go         = aw_got && w_got && !s_axi_bvalid;
  assign wr_hit        = wr_go && mapped(aw_addr);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      aw_got  <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got  <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_got  <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      w_got  <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got  <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_got  <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Software-written registers
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      task_reg <= '0;
      lba_cur  <= '0;
      lba_prv  <= '0;
      unit_reg <= UNIT_RST;
      min_reg  <= MIN_RST;
      irq_msk  <= '0;
    end else if (wr_hit) begin
      case (aw_addr[5:2])
        REG_TASK[5:2]:    task_reg <= merge(task_reg, w_data, w_strb);
        REG_LBA_CUR[5:2]: lba_cur  <= 24'(merge(32'(lba_cur), w_data,
                                                w_strb));
        REG_LBA_PRV[5:2]: lba_prv  <= 24'(merge(32'(lba_prv), w_data,
                                                w_strb));
        REG_UNIT[5:2]:    unit_reg <= merge(unit_reg, w_data, w_strb);
        REG_MIN[5:2]:     min_reg  <= merge(min_reg, w_data, w_strb);
        REG_IRQ_MSK[5:2]: irq_msk  <= w_data[2:0];
        default:          ;
      endcase
    end
  end

  // Writing the command register starts the command; ignored when busy
  assign cmd_go = wr_hit && (aw_addr == REG_CMD) && (state == SRPD_IDLE);

  // A stream-configuration write stores that stream's default limit
  assign mif.we    = wr_hit && (aw_addr == REG_SDEF);
  assign mif.waddr = w_data[SDEF_SID_LSB +: SID_W];
  assign mif.wdata = w_data[DEF_W-1:0];
  assign mif.raddr = task_reg[TASK_SID_LSB +: SID_W];

  srpd_stream_mem u_mem (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .mp      (mif.mem)
  );

  // --------------------------------------------------------------
  // Parameter decode, latched when the command is written
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      xfer_sectors    <= '0;
      start_lba       <= '0;
      read_continuous <= 1'b0;
    end else if (cmd_go) begin
      if (task_reg[TASK_SCP_LSB +: 8] == 8'h00 &&
          task_reg[TASK_SCC_LSB +: 8] == 8'h00) begin
        xfer_sectors <= XFER_MAX;
      end else begin
        xfer_sectors <= {1'b0, task_reg[TASK_SCP_LSB +: 8],
                         task_reg[TASK_SCC_LSB +: 8]};
      end
      start_lba       <= {lba_prv, lba_cur};
      read_continuous <= task_reg[TASK_RC_BIT];
    end
  end

  // --------------------------------------------------------------
  // Limit selection, done in the cycle after the command write
  // --------------------------------------------------------------
  always_comb begin
    req_on = 1'b1;
    req_us = srpd_scale(16'(task_reg[TASK_FEAT_LSB +: 8]),
                        unit_reg);
    if (task_reg[TASK_FEAT_LSB +: 8] == 8'h00) begin
      req_us = srpd_scale(mif.rdata, unit_reg);
      req_on = mif.rvalid && (mif.rdata != '0);
    end
    if (req_us < 48'(min_reg)) begin
      req_us = 48'(min_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      limit_us <= '0;
      limit_on <= 1'b0;
    end else if (state == SRPD_LOOKUP) begin
      limit_us <= req_us;
      limit_on <= req_on;
    end
  end

  // --------------------------------------------------------------
  // Command sequencing
  // --------------------------------------------------------------
  // The microsecond count already runs during the lookup cycle, so the
  // limit is measured from the command write itself
  assign expired = (state == SRPD_RUN) && limit_on &&
                   (us_cnt >= limit_us);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= SRPD_IDLE;
    end else begin
      case (state)
        SRPD_IDLE:   if (cmd_go) state <= SRPD_LOOKUP;
        SRPD_LOOKUP: state <= SRPD_RUN;
        SRPD_RUN:    if (cmd_complete || expired) state <= SRPD_IDLE;
        default:     state <= SRPD_IDLE;
      endcase
    end
  end

  assign cmd_active = (state != SRPD_IDLE);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tick_cnt <= '0;
      us_cnt   <= '0;
    end else if (cmd_go) begin
      tick_cnt <= '0;
      us_cnt   <= '0;
    end else if (cmd_active) begin
      if (tick_cnt == TICK_MAX) begin
        tick_cnt <= '0;
        us_cnt   <= us_cnt + 48'h1;
      end else begin
        tick_cnt <= tick_cnt + 7'h1;
      end
    end
  end

  // Expiry wins over a completion in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmd_abort <= 1'b0;
    end else begin
      cmd_abort <= expired;
    end
  end

  // --------------------------------------------------------------
  // Ending status and error log
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      time_limit_expired_flag <= 1'b0;
    end else if (cmd_go) begin
      time_limit_expired_flag <= 1'b0;
    end else if (expired) begin
      time_limit_expired_flag <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stream_error_flag <= 1'b0;
      err_flag          <= 1'b0;
    end else if (cmd_go) begin
      stream_error_flag <= 1'b0;
      err_flag          <= 1'b0;
    end else if (state == SRPD_RUN && (expired || media_error)) begin
      if (read_continuous) begin
        stream_error_flag <= 1'b1;
        err_flag          <= 1'b0;
      end else begin
        err_flag          <= 1'b1;
      end
    end
  end

  // In read-continuous mode only the first failing sector is kept; later errors add to the count
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      err_lba <= '0;
      err_cnt <= '0;
    end else if (cmd_go) begin
      err_lba <= '0;
      err_cnt <= '0;
    end else if (state == SRPD_RUN && media_error && read_continuous) begin
      if (!stream_error_flag) begin
        err_lba <= error_lba;
        err_cnt <= error_count;
      end else begin
        err_cnt <= err_cnt + error_count;
      end
    end
  end

  // --------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------
  always_comb begin
    irq_set               = '0;
    irq_set[IRQ_DONE_BIT] = (state == SRPD_RUN) && (cmd_complete || expired);
    irq_set[IRQ_EXP_BIT]  = expired;
    irq_set[IRQ_SERR_BIT] = (state == SRPD_RUN) && read_continuous &&
                            (expired || media_error);
  end

  // A new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_st <= '0;
    end else if (wr_hit && aw_addr == REG_IRQ_ST && w_strb[0]) begin
      irq_st <= (irq_st & ~w_data[2:0]) | irq_set;
    end else begin
      irq_st <= irq_st | irq_set;
    end
  end

  assign irq = |(irq_st & irq_msk);

  // --------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit        = mapped(s_axi_araddr);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata  <= '0;
      case (s_axi_araddr[5:2])
        REG_TASK[5:2]:    s_axi_rdata <= task_reg;
        REG_LBA_CUR[5:2]: s_axi_rdata <= 32'(lba_cur);
        REG_LBA_PRV[5:2]: s_axi_rdata <= 32'(lba_prv);
        REG_UNIT[5:2]:    s_axi_rdata <= unit_reg;
        REG_MIN[5:2]:     s_axi_rdata <= min_reg;
        REG_STAT[5:2]: begin
          s_axi_rdata[STAT_ERR_BIT]  <= err_flag;
          s_axi_rdata[STAT_SE_BIT]   <= stream_error_flag;
          s_axi_rdata[STAT_BSY_BIT]  <= cmd_active;
          s_axi_rdata[ERR_TIME_LIMIT_EXPIRED_FLAG_BIT]  <= time_limit_expired_flag;
          s_axi_rdata[STAT_LIM_BIT]  <= limit_on;
        end
        REG_XFER[5:2]:    s_axi_rdata <= 32'(xfer_sectors);
        REG_LIMIT[5:2]:   s_axi_rdata <= limit_us[31:0];
        REG_ELBA_LO[5:2]: s_axi_rdata <= err_lba[31:0];
        REG_ELBA_HI[5:2]: s_axi_rdata <= {err_cnt, err_lba[47:32]};
        REG_IRQ_ST[5:2]:  s_axi_rdata <= 32'(irq_st);
        REG_IRQ_MSK[5:2]: s_axi_rdata <= 32'(irq_msk);
        default:          s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : srpd_top
`default_nettype wire

// File: rtl/srpd_pkg.sv
package srpd_pkg;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_HZ   = 100_000_000;
  localparam int TICK_US  = 1;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [6:0] TICK_MAX = 7'(TICK_CYC - 1);

  // --------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------
  localparam logic [5:0] REG_TASK    = 6'h00;
  localparam logic [5:0] REG_LBA_CUR = 6'h04;
  localparam logic [5:0] REG_LBA_PRV = 6'h08;
  localparam logic [5:0] REG_CMD     = 6'h0C;
  localparam logic [5:0] REG_UNIT    = 6'h10;
  localparam logic [5:0] REG_MIN     = 6'h14;
  localparam logic [5:0] REG_SDEF    = 6'h18;
  localparam logic [5:0] REG_STAT    = 6'h1C;
  localparam logic [5:0] REG_XFER    = 6'h20;
  localparam logic [5:0] REG_LIMIT   = 6'h24;
  localparam logic [5:0] REG_ELBA_LO = 6'h28;
  localparam logic [5:0] REG_ELBA_HI = 6'h2C;
  localparam logic [5:0] REG_IRQ_ST  = 6'h30;
  localparam logic [5:0] REG_IRQ_MSK = 6'h34;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int TASK_FEAT_LSB = 0;
  localparam int TASK_SCC_LSB  = 8;
  localparam int TASK_SCP_LSB  = 16;
  localparam int TASK_RC_BIT   = 24;
  localparam int TASK_SID_LSB  = 25;
  localparam int SDEF_SID_LSB  = 16;
  localparam int STAT_ERR_BIT  = 0;
  localparam int STAT_SE_BIT   = 5;
  localparam int STAT_BSY_BIT  = 7;
  localparam int ERR_TIME_LIMIT_EXPIRED_FLAG_BIT  = 8;
  localparam int STAT_LIM_BIT  = 16;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_EXP_BIT   = 1;
  localparam int IRQ_SERR_BIT  = 2;

  // --------------------------------------------------------------
  // Sizes and reset values
  // --------------------------------------------------------------
  localparam int SID_W   = 3;
  localparam int DEF_W   = 16;
  localparam int STREAMS = 8;
  localparam logic [31:0] UNIT_RST = 32'h0000_0001;
  localparam logic [31:0] MIN_RST  = 32'h0000_0064;
  localparam logic [16:0] XFER_MAX = 17'h1_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRPD_IDLE   = 2'b00,
    SRPD_LOOKUP = 2'b01,
    SRPD_RUN    = 2'b11
  } srpd_state_t;

  function automatic logic [47:0] srpd_scale(input logic [15:0] v,
                                             input logic [31:0] u);
    srpd_scale = 48'(v) * 48'(u);
  endfunction : srpd_scale

endpackage : srpd_pkg

// File: rtl/srpd_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface srpd_mem_if;
  import srpd_pkg::*;
  logic             we;
  logic [SID_W-1:0] waddr;
  logic [DEF_W-1:0] wdata;
  logic [SID_W-1:0] raddr;
  logic [DEF_W-1:0] rdata;
  logic             rvalid;
  modport ctrl (output we, waddr, wdata, raddr, input rdata, rvalid);
  modport mem  (input we, waddr, wdata, raddr, output rdata, rvalid);
endinterface : srpd_mem_if
`default_nettype wire

// File: rtl/srpd_stream_mem.sv
`timescale 1ns/1ps
`default_nettype none
module srpd_stream_mem
  import srpd_pkg::*;
(
  input wire logic   sys_clk, // Clock
  input wire logic   resetn,  // Sync reset, active low
  srpd_mem_if.mem    mp       // Default-limit port
);
  logic [DEF_W-1:0]   store [STREAMS];
  logic [STREAMS-1:0] seen;

  // Seen bits mark streams that have been configured since reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      seen <= '0;
    end else if (mp.we) begin
      seen[mp.waddr] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (mp.we) begin
      store[mp.waddr] <= mp.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mp.rdata  <= '0;
      mp.rvalid <= 1'b0;
    end else begin
      mp.rdata  <= store[mp.raddr];
      mp.rvalid <= seen[mp.raddr];
    end
  end
endmodule : srpd_stream_mem
`default_nettype wire

// File: verif/srpd_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module srpd_top_asserts
  import srpd_pkg::*;
(
  input wire logic        sys_clk,       // Clock
  input wire logic        resetn,        // Sync reset, active low
  input wire logic [5:0]  s_axi_awaddr,  // Write address
  input wire logic        s_axi_awvalid, // Write address valid
  input wire logic        s_axi_awready, // Write address ready
  input wire logic        s_axi_wvalid,  // Write data valid
  input wire logic        s_axi_wready,  // Write data ready
  input wire logic        s_axi_bvalid,  // Write response valid
  input wire logic        s_axi_arvalid, // Read address valid
  input wire logic        s_axi_arready, // Read address ready
  input wire logic        s_axi_rvalid,  // Read data valid
  input wire logic        cmd_complete,  // Done pulse
  input wire logic [16:0] xfer_sectors,  // Decoded count
  input wire logic        cmd_active,    // Command under way
  input wire logic        cmd_abort      // Expiry pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_cmd_wr;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == REG_CMD
      && s_axi_wvalid && s_axi_wready && !cmd_active;
  endsequence
  // Two active cycles in a row means the command has left lookup
  sequence s_run;
    cmd_active ##1 cmd_active;
  endsequence

  a_bresp_timing: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_ready_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
    else $error("read data late");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_cmd_start: assert property (s_cmd_wr |-> ##[1:2] cmd_active)
    else $error("command did not start");
  a_complete_end: assert property (s_run ##0 cmd_complete
      |=> !cmd_active)
    else $error("command outlived completion");
  a_abort_pulse: assert property (cmd_abort |=> !cmd_abort)
    else $error("abort longer than one cycle");
  a_abort_stops: assert property (cmd_abort |-> !cmd_active
      && $past(cmd_active))
    else $error("abort without stopping command");
  a_zero_count: assert property (cmd_active
      |-> xfer_sectors != 17'h0_0000
      && (!xfer_sectors[16] || xfer_sectors[15:0] == 16'h0000))
    else $error("sector count out of range");
  a_count_held: assert property (s_run |-> $stable(xfer_sectors))
    else $error("sector count moved mid command");
endmodule : srpd_top_asserts

bind srpd_top srpd_top_asserts srpd_top_asserts_i (.*);
`default_nettype wire

// File: verif/srpd_media_model.sv
`timescale 1ns/1ps
`default_nettype none
module srpd_media_model
  import srpd_pkg::*;
(
  input  wire logic        sys_clk,      // Clock
  input  wire logic        resetn,       // Sync reset, active low
  input  wire logic        cmd_active,   // Command under way
  input  wire logic [15:0] done_cyc,     // Cycles to finish, 0 never
  input  wire logic [15:0] fail_cyc,     // Cycle of sector error, 0 none
  input  wire logic [47:0] bad_lba,      // Failing sector to report
  input  wire logic [15:0] bad_cnt,      // Suspect sector count
  output logic             cmd_complete, // Done pulse
  output logic             media_error,  // Error pulse
  output logic [47:0]      error_lba,    // Valid with media_error
  output logic [15:0]      error_count   // Valid with media_error
);
  logic [15:0] cyc;

  always_ff @(posedge sys_clk) begin
    if (!resetn || !cmd_active) cyc <= 16'h0000;
    else cyc <= cyc + 16'h0001;
  end
  always_ff @(posedge sys_clk) begin
    cmd_complete <= resetn && cmd_active && done_cyc != 16'h0000
      && cyc == done_cyc;
    media_error  <= resetn && cmd_active && fail_cyc != 16'h0000
      && cyc == fail_cyc;
  end
  // Fields are garbage outside the pulse so a late sample is caught
  assign error_lba   = media_error ? bad_lba : ~bad_lba;
  assign error_count = media_error ? bad_cnt : ~bad_cnt;
endmodule : srpd_media_model
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import srpd_pkg::*;
  localparam logic [31:0] U = 32'h0000_0003, MN = 32'h0000_0005;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        sys_clk = 1'b0, resetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [15:0] done_cyc = 16'h0000, fail_cyc = 16'h0000, bad_cnt = 16'h0000;
  logic [47:0] bad_lba = 48'h0000_0000_0000, lba;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, cmd_complete, media_error, cmd_active;
  wire         cmd_abort, irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [16:0] xfer_sectors;
  wire  [47:0] start_lba, error_lba;
  wire  [15:0] error_count;
  int          err_count = 0, n_checks = 0, cyc = 0, seed = 14036, n, i;
  logic [31:0] d;
  logic [1:0]  r;
  logic [7:0]  f;
  logic [15:0] sc;
  logic        ab;

  srpd_top         srpd_top_i (.*);
  srpd_media_model srpd_media_model_i (.*);

  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  // --------------------------------------------------------------
  // Bus tasks and expectations
  // --------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Ready is judged at the falling edge, where it already equals its value
  // at the coming rising edge, so no race with the design's updates
  task automatic wr(input logic [5:0] a, input logic [31:0] v,
    output logic [1:0] rs);
    logic ah, wh, bh;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge sys_clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge sys_clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] v,
    output logic [1:0] rs);
    logic ah, rh;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge sys_clk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      v  = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge sys_clk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  task automatic w(input logic [5:0] a, input logic [31:0] v);
    logic [1:0] rs;
    wr(a, v, rs);
    chk(48'(rs), 48'(RESP_OKAY));
  endtask : w

  task automatic rc(input logic [5:0] a, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk(48'(v & m), 48'(e));
  endtask : rc

  function automatic logic [31:0] exp_lim(input logic [31:0] raw);
    exp_lim = (raw < MN) ? MN : raw;
  endfunction : exp_lim

  function automatic logic [16:0] exp_xfer(input logic [15:0] s);
    exp_xfer = (s == 16'h0000) ? XFER_MAX : {1'b0, s};
  endfunction : exp_xfer

  task automatic run(input logic [7:0] fb, input logic [15:0] s,
                     input logic rcb, input logic [2:0] sid,
                     input logic [15:0] dc);
    w(REG_TASK, {4'h0, sid, rcb, s[15:8], s[7:0], fb});
    w(REG_LBA_CUR, {8'h00, lba[23:0]});
    w(REG_LBA_PRV, {8'h00, lba[47:24]});
    done_cyc <= dc;
    w(REG_CMD, 32'h0000_0000);
    chk(48'(xfer_sectors), 48'(exp_xfer(s)));
    chk(start_lba, lba);
  endtask : run

  task automatic wait_idle();
    n  = 0;
    ab = 1'b0;
    do begin
      @(negedge sys_clk);
      n++;
      ab = ab | cmd_abort;
    end while (cmd_active);
    @(posedge sys_clk);
  endtask : wait_idle

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rc(REG_UNIT, ALL, UNIT_RST);
    rc(REG_MIN, ALL, MIN_RST);
    rd(6'h38, d, r);
    chk(48'(r), 48'(RESP_SLVERR));
    wr(6'h3C, ALL, r);
    chk(48'(r), 48'(RESP_SLVERR));
    chk(48'(irq), 48'h1 - 48'h1);
    $display("test reset done");
    w(REG_UNIT, U);
    w(REG_MIN, MN);
    w(REG_SDEF, {13'h0000, 3'h2, 16'h0004});
    w(REG_IRQ_MSK, 32'h0000_0007);
    for (i = 0; i < 6; i++) begin
      f   = (i == 0) ? 8'h01 : {2'b00, 6'($random(seed))} + 8'h02;
      sc  = (i == 1) ? 16'h0000 : (i == 2) ? 16'hFFFF : 16'($random(seed));
      lba = {16'($random(seed)), 32'($random(seed))};
      run(f, sc, 1'b0, 3'h0, 16'h001E);
      rc(REG_LIMIT, ALL, exp_lim(32'(f) * U));
      rc(REG_STAT, 32'h0001_0080, 32'h0001_0080);
      rc(REG_XFER, ALL, 32'(exp_xfer(sc)));
      wait_idle();
      chk(48'(ab), 48'h0);
    end
    chk(48'(irq), 48'h1);
    w(REG_IRQ_ST, 32'h0000_0007);
    chk(48'(irq), 48'h0);
    $display("test decode done");
    run(8'h00, 16'h0010, 1'b0, 3'h2, 16'h001E);
    rc(REG_LIMIT, ALL, exp_lim(32'h0000_0004 * U));
    rc(REG_STAT, 32'h0001_0000, 32'h0001_0000);
    wait_idle();
    for (i = 0; i < 2; i++) begin
      if (i == 1) w(REG_SDEF, {13'h0000, 3'h2, 16'h0000});
      run(8'h00, 16'h0010, 1'b0, (i == 1) ? 3'h2 : 3'h5, 16'h001E);
      rc(REG_STAT, 32'h0001_0000, 32'h0000_0000);
      wait_idle();
      chk(48'(ab), 48'h0);
    end
    $display("test default done");
    w(REG_IRQ_ST, 32'h0000_0007);
    run(8'h02, 16'h0100, 1'b1, 3'h0, 16'h0000);
    wait_idle();
    chk(48'(ab), 48'h1);
    chk(48'(n >= 590 && n <= 710), 48'h1);
    rc(REG_STAT, 32'h0000_01A1, 32'h0000_0120);
    rc(REG_IRQ_ST, ALL, 32'h0000_0007);
    w(REG_IRQ_MSK, 32'h0000_0000);
    chk(48'(irq), 48'h0);
    w(REG_IRQ_MSK, 32'h0000_0007);
    chk(48'(irq), 48'h1);
    w(REG_IRQ_ST, 32'h0000_0007);
    rc(REG_IRQ_ST, ALL, 32'h0000_0000);
    chk(48'(irq), 48'h0);
    $display("test expiry done");
    bad_lba  <= {16'($random(seed)), 32'($random(seed))};
    bad_cnt  <= 16'($random(seed));
    fail_cyc <= 16'h000A;
    run(8'h32, 16'h0040, 1'b1, 3'h0, 16'h0028);
    wait_idle();
    rc(REG_ELBA_LO, ALL, bad_lba[31:0]);
    rc(REG_ELBA_HI, ALL, {bad_cnt, bad_lba[47:32]});
    rc(REG_STAT, 32'h0000_0021, 32'h0000_0020);
    fail_cyc <= 16'h0000;
    $display("test stream error done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
